// ==== common/sdi_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface sdi_if;
	logic reset_n;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [sdi_pkg::BA_W-1:0] ba;
	logic [sdi_pkg::ADDR_W-1:0] addr;
	logic termination_enable_in;

	modport ctrl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		termination_enable_in);
	modport mem (input reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		termination_enable_in);
endinterface
`default_nettype wire

// ==== common/sdi_pkg.sv ====
`default_nettype none
package sdi_pkg;
	// clock and time units
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PS_PER_NS = 1000;
	localparam int PS_PER_US = 1000000;
	// least times, rounded up to whole cycles
	localparam int RESET_HOLD_US = 200;
	localparam int RESET_HOLD_CYC =
		(RESET_HOLD_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WARM_HOLD_NS = 100;
	localparam int WARM_HOLD_CYC =
		(WARM_HOLD_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CKE_LEAD_NS = 10;
	localparam int CKE_LEAD_CYC =
		(CKE_LEAD_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INIT_WAIT_US = 500;
	localparam int INIT_WAIT_CYC =
		(INIT_WAIT_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLK_STABLE_NS = 10;
	localparam int CLK_STABLE_TCK = 5;
	localparam int CLK_STABLE_NS_CYC =
		(CLK_STABLE_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLK_STABLE_CYC = (CLK_STABLE_NS_CYC > CLK_STABLE_TCK) ?
		CLK_STABLE_NS_CYC : CLK_STABLE_TCK;
	localparam int XPR_MIN_TCK = 5;
	// memory timings in cycles, plain defaults
	localparam int XS_CYC = 40;
	localparam int MRD_CYC = 4;
	localparam int MOD_CYC = 12;
	localparam int DLLK_CYC = 512;
	localparam int ZQINIT_CYC = 512;
	// widths
	localparam int ADDR_W = 14;
	localparam int BA_W = 3;
	localparam int CNT_W = 17;
	localparam int WB_ADR_W = 8;
	// command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MODE_WRITE = 4'h0;
	localparam logic [3:0] CMD_LONG_CAL = 4'h6;
	localparam logic [3:0] CMD_NO_OPERATION = 4'h7;
	localparam logic [3:0] CMD_DESELECT = 4'hF;
	// mode register fields
	localparam int MR1_DLL_OFF_BIT = 0;
	localparam int MR0_DLL_RESET_BIT = 8;
	localparam int MR3_MPR_EN_BIT = 2;
	localparam logic [ADDR_W-1:0] MR0_KEEP = 14'h1FFF;
	localparam logic [ADDR_W-1:0] MR1_KEEP = 14'h1AFF;
	localparam logic [ADDR_W-1:0] MR2_KEEP = 14'h06FF;
	localparam logic [ADDR_W-1:0] MR3_KEEP = 14'h0007;
	// register map of the controller
	localparam logic [WB_ADR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [WB_ADR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [WB_ADR_W-1:0] REG_MRVAL0 = 8'h08;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_WARM_BIT = 1;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;

	// clears reserved bits; forces dll enable in register 1 and dll reset in 0
	function automatic logic [ADDR_W-1:0] sdi_mr_value(
		input logic [1:0] idx, input logic [ADDR_W-1:0] raw);
		logic [ADDR_W-1:0] v;
		v = raw;
		case (idx)
			2'h0: begin
				v = raw & MR0_KEEP;
				v[MR0_DLL_RESET_BIT] = 1'b1;
			end
			2'h1: begin
				v = raw & MR1_KEEP;
				v[MR1_DLL_OFF_BIT] = 1'b0;
			end
			2'h2: v = raw & MR2_KEEP;
			default: v = raw & MR3_KEEP;
		endcase
		return v;
	endfunction
endpackage
`default_nettype wire

// ==== rtl/sdi_ctrl.sv ====
// How it works
// - clock enable low 10 ns before release
// - wait 500 us before raising clock enable
// - clock stable max(10 ns, 5 cycles) first
// - idle command registered before clock enable
// - clock enable stays high through init
// - memory termination off until clock enable
// - termination input low through init
// - exit-reset wait before first mode write
// - order 2,3,1,0 then long calibration
// - mode write encoding and bank select
// - A0 low enables, A8 high resets DLL
// - warm reset 100 ns, restart sequence
// - write every mode register
// - drive every address field each write
// - mode writes spaced by write spacing
// - update delay before other commands
// - rewrites only when memory idle
// - reserved bits written as zero
// - write recovery field rounded up by software, not by the controller
// - termination value restrictions during writes left to software
// - readout select ignored when disabled
`timescale 1ns/100ps
`default_nettype none
module sdi_ctrl #(
	parameter int RESET_HOLD_CYC = sdi_pkg::RESET_HOLD_CYC,
	parameter int INIT_WAIT_CYC = sdi_pkg::INIT_WAIT_CYC,
	parameter int XS_CYC = sdi_pkg::XS_CYC,
	parameter int MRD_CYC = sdi_pkg::MRD_CYC,
	parameter int MOD_CYC = sdi_pkg::MOD_CYC,
	parameter int DLLK_CYC = sdi_pkg::DLLK_CYC,
	parameter int ZQINIT_CYC = sdi_pkg::ZQINIT_CYC
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sdi_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	sdi_if.ctrl dram
);
	typedef enum logic [3:0] {C_IDLE, C_RST_HOLD, C_INIT_WAIT, C_CLK_STABLE,
		C_XPR, C_MRS, C_MRD, C_ZQ, C_LOCK, C_DONE} sdi_cstate_t;
	localparam int CW = sdi_pkg::CNT_W;
	localparam int AW = sdi_pkg::ADDR_W;
	localparam int PWR_HOLD = (RESET_HOLD_CYC > sdi_pkg::CKE_LEAD_CYC) ?
		RESET_HOLD_CYC : sdi_pkg::CKE_LEAD_CYC;
	localparam int WARM_HOLD = (sdi_pkg::WARM_HOLD_CYC >
		sdi_pkg::CKE_LEAD_CYC) ? sdi_pkg::WARM_HOLD_CYC : sdi_pkg::CKE_LEAD_CYC;
	localparam int XPR_CYC = (XS_CYC > sdi_pkg::XPR_MIN_TCK) ?
		XS_CYC : sdi_pkg::XPR_MIN_TCK;
	localparam int LOCK_CYC = (DLLK_CYC > ZQINIT_CYC) ? DLLK_CYC : ZQINIT_CYC;

	sdi_cstate_t state, next_state;
	logic [CW-1:0] cnt, next_cnt;
	logic [1:0] step, next_step;
	logic rst_n, next_rst_n, cke, next_cke, done, next_done;
	logic [3:0] cmd, next_cmd;
	logic [sdi_pkg::BA_W-1:0] ba, next_ba;
	logic [AW-1:0] addr, next_addr;
	logic term_en;

	logic [AW-1:0] mrval [4];
	logic [AW-1:0] next_mrval [4];
	logic warm, next_warm, start, next_start, next_ack;
	logic [31:0] next_dat;
	logic req, wr;
	logic [1:0] cur_mr;

	function automatic logic [CW-1:0] cyc(input int n);
		return (n > 1) ? CW'(n - 1) : '0;
	endfunction

	// register index written at each step of the sequence
	function automatic logic [1:0] mr_of_step(input logic [1:0] s);
		case (s)
			2'h0: return 2'h2;
			2'h1: return 2'h3;
			2'h2: return 2'h1;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic is_reg(input logic [sdi_pkg::WB_ADR_W-1:0] a,
		input logic [sdi_pkg::WB_ADR_W-1:0] r);
		return a[sdi_pkg::WB_ADR_W-1:2] == r[sdi_pkg::WB_ADR_W-1:2];
	endfunction

	assign req = wb_cyc_i && wb_stb_i;
	// a write lands at the edge where the master samples ack
	assign wr = req && wb_ack_o && wb_we_i;
	assign cur_mr = mr_of_step(step);

	always_comb begin
		next_ack = req && !wb_ack_o;
		next_dat = wb_dat_o;
		next_warm = warm;
		next_start = 1'b0;
		next_mrval = mrval;
		if (req && !wb_ack_o) begin
			next_dat = '0;
			if (is_reg(wb_adr_i, sdi_pkg::REG_CTRL))
				next_dat[sdi_pkg::CTRL_WARM_BIT] = warm;
			else if (is_reg(wb_adr_i, sdi_pkg::REG_STATUS)) begin
				next_dat[sdi_pkg::STATUS_BUSY_BIT] =
					(state != C_IDLE) && (state != C_DONE);
				next_dat[sdi_pkg::STATUS_DONE_BIT] = done;
				next_dat[7:4] = state;
			end
			for (int i = 0; i < 4; i++) begin
				if (is_reg(wb_adr_i, sdi_pkg::REG_MRVAL0 + 8'(4 * i)))
					next_dat[AW-1:0] = mrval[i];
			end
		end
		if (wr && is_reg(wb_adr_i, sdi_pkg::REG_CTRL) && wb_sel_i[0]) begin
			next_warm = wb_dat_i[sdi_pkg::CTRL_WARM_BIT];
			next_start = wb_dat_i[sdi_pkg::CTRL_START_BIT];
		end
		// software supplies the rounded-up recovery field
		// software supplies an allowed termination value
		for (int i = 0; i < 4; i++) begin
			if (wr && is_reg(wb_adr_i, sdi_pkg::REG_MRVAL0 + 8'(4 * i))) begin
				if (wb_sel_i[0])
					next_mrval[i][7:0] = wb_dat_i[7:0];
				if (wb_sel_i[1])
					next_mrval[i][AW-1:8] = wb_dat_i[AW-1:8];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			warm <= 1'b0;
			start <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				mrval[i] <= '0;
			end
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			warm <= next_warm;
			start <= next_start;
			mrval <= next_mrval;
		end
	end

	always_comb begin
		next_state = state;
		next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
		next_step = step;
		next_rst_n = rst_n;
		next_cke = cke;
		next_done = done;
		next_cmd = sdi_pkg::CMD_NO_OPERATION;
		next_ba = '0;
		next_addr = '0;
		case (state)
			C_IDLE, C_DONE: begin
				// start ignored while a sequence runs
				if (start) begin
					next_state = C_RST_HOLD;
					next_rst_n = 1'b0;
					next_cke = 1'b0;
					next_done = 1'b0;
					next_cnt = warm ? cyc(WARM_HOLD) : cyc(PWR_HOLD);
				end
			end
			C_RST_HOLD: begin
				if (cnt == '0) begin
					next_state = C_INIT_WAIT;
					next_rst_n = 1'b1;
					next_cnt = cyc(INIT_WAIT_CYC);
				end
			end
			C_INIT_WAIT: begin
				if (cnt == '0) begin
					next_state = C_CLK_STABLE;
					next_cnt = cyc(sdi_pkg::CLK_STABLE_CYC);
				end
			end
			C_CLK_STABLE: begin
				if (cnt == '0) begin
					next_state = C_XPR;
					next_cke = 1'b1;
					next_cnt = cyc(XPR_CYC);
				end
			end
			C_XPR: begin
				if (cnt == '0) begin
					next_state = C_MRS;
					next_step = 2'h0;
				end
			end
			C_MRS: begin
				next_cmd = sdi_pkg::CMD_MODE_WRITE;
				next_ba = {1'b0, cur_mr};
				next_addr = sdi_pkg::sdi_mr_value(cur_mr, mrval[cur_mr]);
				next_state = C_MRD;
				next_cnt = (step == 2'h3) ? cyc(MOD_CYC - 1) :
					cyc(MRD_CYC - 1);
			end
			C_MRD: begin
				if (cnt == '0) begin
					if (step == 2'h3)
						next_state = C_ZQ;
					else begin
						next_state = C_MRS;
						next_step = step + 2'h1;
					end
				end
			end
			C_ZQ: begin
				next_cmd = sdi_pkg::CMD_LONG_CAL;
				next_state = C_LOCK;
				next_cnt = cyc(LOCK_CYC);
			end
			C_LOCK: begin
				if (cnt == '0) begin
					next_state = C_DONE;
					next_done = 1'b1;
				end
			end
			default: next_state = C_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= C_IDLE;
			cnt <= '0;
			step <= '0;
			rst_n <= 1'b0;
			cke <= 1'b0;
			done <= 1'b0;
			cmd <= sdi_pkg::CMD_NO_OPERATION;
			ba <= '0;
			addr <= '0;
			term_en <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			step <= next_step;
			rst_n <= next_rst_n;
			cke <= next_cke;
			done <= next_done;
			cmd <= next_cmd;
			ba <= next_ba;
			addr <= next_addr;
			term_en <= 1'b0;
		end
	end

	assign dram.reset_n = rst_n;
	assign dram.cke = cke;
	assign {dram.cs_n, dram.ras_n, dram.cas_n, dram.we_n} = cmd;
	assign dram.ba = ba;
	assign dram.addr = addr;
	assign dram.termination_enable_in = term_en;
endmodule
`default_nettype wire

// ==== rtl/sdi_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdi_mem #(
	parameter int INIT_WAIT_CYC = sdi_pkg::INIT_WAIT_CYC,
	parameter int DLLK_CYC = sdi_pkg::DLLK_CYC,
	parameter int ZQINIT_CYC = sdi_pkg::ZQINIT_CYC
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	sdi_if.mem dram,
	output logic [sdi_pkg::ADDR_W-1:0] mode_reg_zero,
	output logic [sdi_pkg::ADDR_W-1:0] mode_reg_one,
	output logic [sdi_pkg::ADDR_W-1:0] mode_reg_two,
	output logic [sdi_pkg::ADDR_W-1:0] mode_reg_three,
	output logic dll_enabled,
	output logic mpr_enable,
	output logic [1:0] mpr_pattern_sel,
	output logic term_active,
	output logic init_ready,
	output logic seq_error
);
	typedef enum logic [1:0] {D_RESET, D_SELF_INIT, D_WAIT_CKE, D_ACTIVE}
		sdi_mstate_t;
	localparam int CW = sdi_pkg::CNT_W;

	sdi_mstate_t state, next_state;
	logic [CW-1:0] cnt, next_cnt, dll_cnt, next_dll_cnt, zq_cnt, next_zq_cnt;
	logic [sdi_pkg::ADDR_W-1:0] mr [4];
	logic [sdi_pkg::ADDR_W-1:0] next_mr [4];
	logic [3:0] written, next_written;
	logic dll_run, next_dll_run, zq_run, next_zq_run;
	logic dll_done, next_dll_done, zq_done, next_zq_done;
	logic prev_idle, next_prev_idle;
	logic next_dll_enabled, next_term, next_ready, next_err;
	logic [3:0] cmd;
	logic [1:0] sel;

	function automatic logic [CW-1:0] cyc(input int n);
		return (n > 1) ? CW'(n - 1) : '0;
	endfunction

	assign cmd = {dram.cs_n, dram.ras_n, dram.cas_n, dram.we_n};
	assign sel = dram.ba[1:0];

	always_comb begin
		next_state = state;
		next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
		next_mr = mr;
		next_written = written;
		next_dll_run = dll_run;
		next_dll_done = dll_done;
		next_zq_run = zq_run;
		next_zq_done = zq_done;
		next_dll_cnt = (dll_cnt != '0) ? dll_cnt - 1'b1 : dll_cnt;
		next_zq_cnt = (zq_cnt != '0) ? zq_cnt - 1'b1 : zq_cnt;
		next_dll_enabled = dll_enabled;
		next_ready = init_ready;
		next_err = seq_error;
		next_prev_idle = (cmd == sdi_pkg::CMD_NO_OPERATION) ||
			(cmd == sdi_pkg::CMD_DESELECT);
		next_term = 1'b0;
		case (state)
			D_RESET: begin
				if (dram.reset_n) begin
					next_state = D_SELF_INIT;
					next_cnt = cyc(INIT_WAIT_CYC);
				end
			end
			D_SELF_INIT: begin
				if (dram.cke)
					next_err = 1'b1;
				if (cnt == '0)
					next_state = D_WAIT_CKE;
			end
			D_WAIT_CKE: begin
				if (dram.cke) begin
					if (!prev_idle)
						next_err = 1'b1;
					next_state = D_ACTIVE;
				end
			end
			D_ACTIVE: begin
				next_term = dram.termination_enable_in;
				if (!dram.cke && !init_ready)
					next_err = 1'b1;
				if (dram.cke && cmd == sdi_pkg::CMD_MODE_WRITE) begin
					next_mr[sel] = dram.addr;
					next_written[sel] = 1'b1;
					if (sel == 2'h1)
						next_dll_enabled =
							!dram.addr[sdi_pkg::MR1_DLL_OFF_BIT];
					if (sel == 2'h0 &&
						dram.addr[sdi_pkg::MR0_DLL_RESET_BIT]) begin
						next_dll_run = 1'b1;
						next_dll_done = 1'b0;
						next_dll_cnt = cyc(DLLK_CYC);
					end
				end
				if (dram.cke && cmd == sdi_pkg::CMD_LONG_CAL) begin
					next_zq_run = 1'b1;
					next_zq_done = 1'b0;
					next_zq_cnt = cyc(ZQINIT_CYC);
				end
				if (dll_run && dll_cnt == '0) begin
					next_dll_run = 1'b0;
					next_dll_done = 1'b1;
				end
				if (zq_run && zq_cnt == '0) begin
					next_zq_run = 1'b0;
					next_zq_done = 1'b1;
				end
				if (written == 4'hF && dll_done && zq_done)
					next_ready = 1'b1;
			end
			default: next_state = D_RESET;
		endcase
		// any reset restarts the whole sequence
		if (!dram.reset_n) begin
			next_state = D_RESET;
			next_written = '0;
			next_ready = 1'b0;
			next_dll_run = 1'b0;
			next_dll_done = 1'b0;
			next_zq_run = 1'b0;
			next_zq_done = 1'b0;
			next_term = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= D_RESET;
			cnt <= '0;
			dll_cnt <= '0;
			zq_cnt <= '0;
			for (int i = 0; i < 4; i++) begin
				mr[i] <= '0;
			end
			written <= '0;
			dll_run <= 1'b0;
			dll_done <= 1'b0;
			zq_run <= 1'b0;
			zq_done <= 1'b0;
			prev_idle <= 1'b0;
			dll_enabled <= 1'b0;
			term_active <= 1'b0;
			init_ready <= 1'b0;
			seq_error <= 1'b0;
			mpr_enable <= 1'b0;
			mpr_pattern_sel <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			dll_cnt <= next_dll_cnt;
			zq_cnt <= next_zq_cnt;
			mr <= next_mr;
			written <= next_written;
			dll_run <= next_dll_run;
			dll_done <= next_dll_done;
			zq_run <= next_zq_run;
			zq_done <= next_zq_done;
			prev_idle <= next_prev_idle;
			dll_enabled <= next_dll_enabled;
			term_active <= next_term;
			init_ready <= next_ready;
			seq_error <= next_err;
			// select bits ignored unless readout enabled
			mpr_enable <= next_mr[3][sdi_pkg::MR3_MPR_EN_BIT];
			mpr_pattern_sel <= next_mr[3][sdi_pkg::MR3_MPR_EN_BIT] ?
				next_mr[3][1:0] : 2'h0;
		end
	end

	assign mode_reg_zero = mr[0];
	assign mode_reg_one = mr[1];
	assign mode_reg_two = mr[2];
	assign mode_reg_three = mr[3];
endmodule
`default_nettype wire

// ==== test/sdi_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdi_monitor #(
	parameter int INIT_WAIT_CYC = sdi_pkg::INIT_WAIT_CYC,
	parameter int XS_CYC = sdi_pkg::XS_CYC,
	parameter int MRD_CYC = sdi_pkg::MRD_CYC,
	parameter int MOD_CYC = sdi_pkg::MOD_CYC
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic reset_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sdi_pkg::BA_W-1:0] ba,
	input wire logic [sdi_pkg::ADDR_W-1:0] addr,
	input wire logic termination_enable_in
);
	localparam int XPR_CYC = (XS_CYC > sdi_pkg::XPR_MIN_TCK) ?
		XS_CYC : sdi_pkg::XPR_MIN_TCK;
	logic [3:0] cmd;
	logic mode_wr, long_cal, cke_q, next_cke_q;
	logic [7:0] gap, next_gap;
	logic [2:0] mw_n, next_mw_n;
	logic [16:0] low_cnt, next_low_cnt, wait_cnt, next_wait_cnt;
	logic [sdi_pkg::ADDR_W-1:0] keep;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign mode_wr = cmd == sdi_pkg::CMD_MODE_WRITE;
	assign long_cal = cmd == sdi_pkg::CMD_LONG_CAL;
	assign keep = (ba == 3'h0) ? sdi_pkg::MR0_KEEP :
		(ba == 3'h1) ? sdi_pkg::MR1_KEEP :
		(ba == 3'h2) ? sdi_pkg::MR2_KEEP : sdi_pkg::MR3_KEEP;
	// spacing counter restarts at clock enable rise and at each mode write
	always_comb begin
		next_cke_q = cke;
		next_gap = (gap == 8'hFF) ? gap : gap + 8'h01;
		next_mw_n = mw_n;
		if (cke && !cke_q) begin
			next_gap = 8'h00;
			next_mw_n = 3'h0;
		end
		if (mode_wr) begin
			next_gap = 8'h00;
			next_mw_n = mw_n + 3'h1;
		end
		next_low_cnt = reset_n ? 17'h00000 : low_cnt + 17'h00001;
		next_wait_cnt = !reset_n ? 17'h00000 :
			(cke ? wait_cnt : wait_cnt + 17'h00001);
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cke_q <= 1'b0;
			gap <= 8'h00;
			mw_n <= 3'h0;
			low_cnt <= 17'h00000;
			wait_cnt <= 17'h00000;
		end else begin
			cke_q <= next_cke_q;
			gap <= next_gap;
			mw_n <= next_mw_n;
			low_cnt <= next_low_cnt;
			wait_cnt <= next_wait_cnt;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_term_low: assert property (
		termination_enable_in == 1'b0) else $error("termination driven");
	chk_cke_lead: assert property (
		$rose(reset_n) |-> !cke && !$past(cke) && !$past(cke, 2))
		else $error("cke not low before reset release");
	chk_init_wait: assert property (
		$rose(cke) |-> wait_cnt >= INIT_WAIT_CYC)
		else $error("cke raised too early");
	chk_idle_before_cke: assert property (
		$rose(cke) |-> $past(cmd) == sdi_pkg::CMD_NO_OPERATION ||
		$past(cmd) == sdi_pkg::CMD_DESELECT) else $error("busy before cke");
	chk_cke_held: assert property (
		$fell(cke) |-> !reset_n) else $error("cke dropped during init");
	chk_exit_wait: assert property (
		mode_wr && mw_n == 3'h0 |-> gap >= XPR_CYC - 1)
		else $error("first mode write too early");
	chk_mode_spacing: assert property (
		mode_wr && mw_n != 3'h0 |-> gap >= MRD_CYC - 1)
		else $error("mode writes too close");
	chk_update_delay: assert property (
		long_cal |-> gap >= MOD_CYC - 1 && mw_n == 3'h4)
		else $error("calibration too early");
	chk_mode_order: assert property (
		mode_wr |-> mw_n < 3'h4 && ba == {1'b0, !mw_n[1], mw_n[0] ^ mw_n[1]})
		else $error("mode write order wrong");
	chk_mode_bits: assert property (
		mode_wr |-> (addr & ~keep) == '0 && (ba != 3'h1 || !addr[0]) &&
		(ba != 3'h0 || addr[8])) else $error("mode value bits wrong");
	chk_reset_hold: assert property (
		$rose(reset_n) |-> low_cnt >= sdi_pkg::WARM_HOLD_CYC)
		else $error("memory reset too short");
	chk_idle_after_cal: assert property (
		long_cal |=> (cmd == sdi_pkg::CMD_NO_OPERATION) [*8])
		else $error("command during lock wait");
endmodule
`default_nettype wire

// ==== test/test_sdram_init_and_mode_setup.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_sdram_init_and_mode_setup;
	logic sys_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_i, wb_dat_o, s;
	logic [13:0] mr0, mr1, mr2, mr3;
	logic dll_en, mpr_en, term_act, ready, seq_err;
	logic [1:0] mpr_sel;
	int err_total, tests_run, cyc_cnt;
	// only the two long waits are shortened; every other timing is default
	localparam int T_RST_HOLD = 30;
	localparam int T_INIT_WAIT = 40;
	sdi_if link ();
	sdi_ctrl #(.RESET_HOLD_CYC(T_RST_HOLD), .INIT_WAIT_CYC(T_INIT_WAIT))
		u_sdi_ctrl (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack),
		.dram(link));
	sdi_mem #(.INIT_WAIT_CYC(T_INIT_WAIT)) u_sdi_mem (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .dram(link),
		.mode_reg_zero(mr0), .mode_reg_one(mr1), .mode_reg_two(mr2),
		.mode_reg_three(mr3), .dll_enabled(dll_en), .mpr_enable(mpr_en),
		.mpr_pattern_sel(mpr_sel), .term_active(term_act),
		.init_ready(ready), .seq_error(seq_err));
	sdi_monitor #(.INIT_WAIT_CYC(T_INIT_WAIT)) mon (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .reset_n(link.reset_n), .cke(link.cke),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
		.we_n(link.we_n), .ba(link.ba), .addr(link.addr),
		.termination_enable_in(link.termination_enable_in));
	task tally_and_finish;
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task note(input logic ok, input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (!ok) begin
			err_total++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task cmp_word(input logic [31:0] g, input logic [31:0] e);
		note(g === e, g, e);
	endtask
	task cmp_mode(input logic [13:0] g, input logic [13:0] e);
		note(g === e, {18'h0, g}, {18'h0, e});
	endtask
	task cmp_bit(input logic g, input logic e);
		note(g === e, {31'h0, g}, {31'h0, e});
	endtask
	task wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] dat, output logic [31:0] rd);
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= sel;
		wb_dat_i <= dat;
		// ack or the bench timeout ends this wait
		do begin
			@(posedge sys_clk);
		end while (wb_ack !== 1'b1);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
		// slave drops ack the cycle after giving it
		cmp_bit(wb_ack, 1'b0);
	endtask
	task run_init(input logic [31:0] ctrl, input logic [3:0][13:0] raw,
		input logic [3:0][13:0] exp, input logic [1:0] sel_exp);
		int n;
		for (int i = 0; i < 4; i++) begin
			wb_xfer(1'b1, sdi_pkg::REG_MRVAL0 + 8'(4 * i), 4'hF,
				{18'h0, raw[i]}, s);
		end
		wb_xfer(1'b1, sdi_pkg::REG_CTRL, 4'hF, ctrl, s);
		wb_xfer(1'b0, sdi_pkg::REG_STATUS, 4'hF, 32'h0, s);
		cmp_bit(s[0], 1'b1);
		cmp_bit(term_act, 1'b0);
		n = 0;
		do begin
			wb_xfer(1'b0, sdi_pkg::REG_STATUS, 4'hF, 32'h0, s);
			n++;
		end while (s[7:4] !== 4'h9 && n < 400);
		repeat (3) @(posedge sys_clk);
		cmp_word(s, 32'h00000092);
		cmp_mode(mr0, exp[0]);
		cmp_mode(mr1, exp[1]);
		cmp_mode(mr2, exp[2]);
		cmp_mode(mr3, exp[3]);
		cmp_bit(ready, 1'b1);
		cmp_bit(dll_en, 1'b1);
		cmp_bit(mpr_en, exp[3][2]);
		cmp_mode({12'h0, mpr_sel}, {12'h0, sel_exp});
		cmp_bit(seq_err, 1'b0);
		cmp_bit(term_act, 1'b0);
	endtask
	task test_regs;
		wb_xfer(1'b0, sdi_pkg::REG_STATUS, 4'hF, 32'h0, s);
		cmp_word(s, 32'h00000000);
		wb_xfer(1'b0, 8'h40, 4'hF, 32'h0, s);
		cmp_word(s, 32'h00000000);
		wb_xfer(1'b1, sdi_pkg::REG_MRVAL0, 4'hF, 32'h00003FFF, s);
		wb_xfer(1'b1, sdi_pkg::REG_MRVAL0, 4'h1, 32'h00000000, s);
		wb_xfer(1'b0, sdi_pkg::REG_MRVAL0, 4'hF, 32'h0, s);
		cmp_word(s, 32'h00003F00);
	endtask
	task test_cold;
		run_init(32'h1, {14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3F00},
			{14'h0007, 14'h06FF, 14'h1AFE, 14'h1F00}, 2'h3);
	endtask
	task test_warm;
		run_init(32'h3, {14'h3FFB, 14'h3918, 14'h2401, 14'h0000},
			{14'h0003, 14'h0018, 14'h0000, 14'h0100}, 2'h0);
		wb_xfer(1'b0, sdi_pkg::REG_CTRL, 4'hF, 32'h0, s);
		cmp_word(s, 32'h00000002);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			tally_and_finish;
		end
	end
	initial begin
		sys_rst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_dat_i = 32'h0;
		err_total = 0;
		tests_run = 0;
		cyc_cnt = 0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		test_regs;
		test_cold;
		test_warm;
		tally_and_finish;
	end
endmodule
`default_nettype wire
